/* File: logic/sfe_regs.vh */
// Offsets, field positions, reset values and timing constants of the erase sequencer
`ifndef SFE_REGS_VH
`define SFE_REGS_VH

// --------------------
// Register offsets
// --------------------
`define SFE_ADDR_CTRL        8'h00
`define SFE_ADDR_PROTECT     8'h04
`define SFE_ADDR_STATUS      8'h08
`define SFE_ADDR_LAST_ERASE  8'h0C
`define SFE_ADDR_ERASE_COUNT 8'h10

// --------------------
// Field positions and reset values
// --------------------
`define SFE_CTRL_WEL_BIT     0
`define SFE_PROT_TB_BIT      3
`define SFE_STAT_BUSY_BIT    0
`define SFE_STAT_WEL_BIT     1
`define SFE_STAT_ASLEEP_BIT  2
`define SFE_STAT_WAKING_BIT  3
`define SFE_LAST_CHIP_BIT    31
`define SFE_RST_PROTECT      4'h0

// --------------------
// Opcodes and identity address
// --------------------
`define SFE_OP_BLOCK_ERASE   8'hD8
`define SFE_OP_CHIP_ERASE_A  8'hC7
`define SFE_OP_CHIP_ERASE_B  8'h60
`define SFE_OP_SLEEP         8'hB9
`define SFE_OP_WAKE_ID       8'hAB
`define SFE_OP_MANU_DEV_ID   8'h90
`define SFE_OP_READ_STATUS   8'h05
`define SFE_ID_ADDR_DEV_1ST  24'h000001

// --------------------
// Self-timed durations
// --------------------
`define SFE_CLK_MHZ             100
`define SFE_BLOCK_ERASE_TIME_US 1000
`define SFE_CHIP_ERASE_TIME_US  8000
`define SFE_SLEEP_ENTRY_US      3
`define SFE_WAKE_US             3
`define SFE_WAKE_ID_US          2

`endif

/* File: logic/sfe_sync.v */
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module sfe_sync
#(
   parameter W = 3
)
(
   // Clock and reset
   input  wire         i_clk,
   input  wire         i_rst_n,
   // Data
   input  wire [W-1:0] i_async,
   input  wire [W-1:0] i_rst_val,
   output wire [W-1:0] o_sync
);

   reg [W-1:0] meta_ff;
   reg [W-1:0] sync_ff;
   reg         init_ff;

   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         meta_ff <= {W{1'b0}};
         sync_ff <= {W{1'b0}};
         init_ff <= 1'b0;
      end
      else
      begin
         meta_ff <= i_async;
         init_ff <= 1'b1;
         sync_ff <= init_ff ? meta_ff : i_rst_val;
      end
   end

   assign o_sync = init_ff ? sync_ff : i_rst_val;

endmodule

/* File: logic/sfe_timer.v */
// Down counter for the self-timed operations
`timescale 1ns/10ps
module sfe_timer
(
   // Clock and reset
   input  wire        i_clk,
   input  wire        i_rst_n,
   // Control
   input  wire        i_load,
   input  wire [31:0] i_count,
   output reg         o_done,
   output wire        o_running
);

   reg [31:0] cnt_ff;
   reg        run_ff;

   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt_ff <= 32'h0;
         run_ff <= 1'b0;
         o_done <= 1'b0;
      end
      else
      begin
         o_done <= 1'b0;
         if (i_load)
         begin
            cnt_ff <= (i_count == 32'h0) ? 32'h1 : i_count;
            run_ff <= 1'b1;
         end
         else if (run_ff)
         begin
            if (cnt_ff == 32'h1)
            begin
               run_ff <= 1'b0;
               o_done <= 1'b1;
            end
            cnt_ff <= cnt_ff - 32'h1;
         end
      end
   end

   assign o_running = run_ff;

endmodule

/* File: logic/sfe_top.v */
// Serial flash erase, sleep and identity command sequencer
//
// Overview of operation
// R1: D8h plus address erases one block
// R2: Erase accepted only with write_enable_latch set
// R3: Block erase needs select_n rise after bit 32
// R4: Busy high during erase, status still readable
// R5: Finished erase clears write_enable_latch
// R6: Protected block erase is skipped
// R7: C7h or 60h erases whole array
// R8: Chip erase needs select_n rise after bit 8
// R9: Chip erase refused if anything protected
// R10: B9h enters sleep after sleep_entry_delay
// R11: Asleep only ABh is recognised
// R12: Reset starts awake
// R13: Bare ABh wakes after wake_delay
// R14: ABh plus three dummies repeats device identity
// R15: Identity read wakes after wake_id_delay
// R16: ABh ignored while busy
// R17: 90h address 0 sends manufacturer then device
// R18: Address 1 swaps order, bytes alternate
// R19: Opcode and address sampled on rising clock
// R20: Block chosen from upper address bits
// R21: Self-timed durations are cycle parameters
`timescale 1ns/10ps
`include "sfe_regs.vh"
module sfe_top
#(
   parameter       BLOCK_BITS      = 3,
   parameter [7:0] MANU_ID         = 8'h5A,
   parameter [7:0] DEV_ID          = 8'h13,
   parameter       BLOCK_ERASE_CYC = `SFE_BLOCK_ERASE_TIME_US * `SFE_CLK_MHZ,
   parameter       CHIP_ERASE_CYC  = `SFE_CHIP_ERASE_TIME_US * `SFE_CLK_MHZ,
   parameter       SLEEP_CYC       = `SFE_SLEEP_ENTRY_US * `SFE_CLK_MHZ,
   parameter       WAKE_CYC        = `SFE_WAKE_US * `SFE_CLK_MHZ,
   parameter       WAKE_ID_CYC     = `SFE_WAKE_ID_US * `SFE_CLK_MHZ
)
(
   // Clock and reset
   input  wire        i_clk,
   input  wire        i_rst_n,
   // Serial link pins
   input  wire        i_select_n,
   input  wire        i_sclk,
   input  wire        i_serial_input_line,
   output reg         o_serial_output,
   output reg         o_serial_output_oe,
   // Register port
   input  wire [7:0]  i_addr,
   input  wire [31:0] i_wdata,
   input  wire        i_wr,
   input  wire        i_rd,
   output reg  [31:0] o_rdata,
   // Erase action
   output reg         o_erase_start,
   output reg         o_erase_all,
   output reg  [7:0]  o_erase_block,
   output reg         o_asleep
);

   // --------------------
   // States
   // --------------------
   localparam [4:0] ST_IDLE  = 5'h01;
   localparam [4:0] ST_ERASE = 5'h02;
   localparam [4:0] ST_ENTER = 5'h04;
   localparam [4:0] ST_SLEEP = 5'h08;
   localparam [4:0] ST_WAKE  = 5'h10;

   localparam [1:0] TX_STATUS = 2'h0;
   localparam [1:0] TX_DEV    = 2'h1;
   localparam [1:0] TX_PAIR   = 2'h2;

   localparam [8:0] NUM_BLK = 9'h001 << BLOCK_BITS;

   // --------------------
   // Pin synchronisers and edges
   // --------------------
   wire [2:0] pins_sync;
   wire       sel_n_s = pins_sync[2];
   wire       sclk_s  = pins_sync[1];
   wire       din_s   = pins_sync[0];
   reg        sel_n_d_ff;
   reg        sclk_d_ff;

   sfe_sync #(.W(3)) u_sync
   (
      .i_clk     (i_clk),
      .i_rst_n   (i_rst_n),
      .i_async   ({i_select_n, i_sclk, i_serial_input_line}),
      .i_rst_val (3'h4),
      .o_sync    (pins_sync)
   );

   wire sclk_rise = sclk_s & ~sclk_d_ff & ~sel_n_s;
   wire sclk_fall = ~sclk_s & sclk_d_ff & ~sel_n_s;
   wire frame_end = sel_n_s & ~sel_n_d_ff;

   // --------------------
   // Control and status registers
   // --------------------
   reg  [4:0]  state_ff;
   reg  [4:0]  nxt_state;
   reg         wel_ff;
   reg  [3:0]  prot_ff;
   reg  [31:0] last_ff;
   reg  [31:0] count_ff;

   wire        busy      = state_ff[1];
   wire        asleep    = state_ff[3] | state_ff[4];
   wire        tb        = prot_ff[`SFE_PROT_TB_BIT];
   wire [2:0]  bp        = prot_ff[2:0];
   wire [7:0]  stat_byte = {2'h0, tb, bp, wel_ff, busy};

   // --------------------
   // Serial shifter
   // --------------------
   reg  [5:0]  bit_cnt_ff;
   reg  [31:0] shift_ff;
   reg  [7:0]  op_ff;
   reg  [7:0]  tx_byte_ff;
   reg  [2:0]  tx_idx_ff;
   reg  [1:0]  tx_mode_ff;
   reg         tx_on_ff;
   reg         tx_alt_ff;
   reg  [7:0]  nxt_byte;

   wire [31:0] shift_in = {shift_ff[30:0], din_s};

   always @*
   begin
      case (tx_mode_ff)
         TX_STATUS: nxt_byte = stat_byte;
         TX_DEV:    nxt_byte = DEV_ID;
         default:   nxt_byte = tx_alt_ff ? DEV_ID : MANU_ID;
      endcase
   end

   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         sel_n_d_ff         <= 1'b1;
         sclk_d_ff          <= 1'b0;
         bit_cnt_ff         <= 6'h00;
         shift_ff           <= 32'h0;
         op_ff              <= 8'h00;
         tx_byte_ff         <= 8'h00;
         tx_idx_ff          <= 3'h0;
         tx_mode_ff         <= TX_STATUS;
         tx_on_ff           <= 1'b0;
         tx_alt_ff          <= 1'b0;
         o_serial_output    <= 1'b0;
         o_serial_output_oe <= 1'b0;
      end
      else
      begin
         sel_n_d_ff <= sel_n_s;
         sclk_d_ff  <= sclk_s;
         if (sel_n_s)
         begin
            bit_cnt_ff         <= 6'h00;
            tx_on_ff           <= 1'b0;
            o_serial_output_oe <= 1'b0;
         end
         // R19: rising edge capture
         else if (sclk_rise)
         begin
            shift_ff <= shift_in;
            if (bit_cnt_ff != 6'h3F)
               bit_cnt_ff <= bit_cnt_ff + 6'h01;
            if (bit_cnt_ff == 6'h07)
            begin
               op_ff <= shift_in[7:0];
               // R4: status readable while busy
               // R11: ignored while asleep
               if (shift_in[7:0] == `SFE_OP_READ_STATUS && !asleep)
               begin
                  tx_on_ff   <= 1'b1;
                  tx_mode_ff <= TX_STATUS;
                  tx_byte_ff <= stat_byte;
                  tx_idx_ff  <= 3'h0;
               end
            end
            if (bit_cnt_ff == 6'h1F && !busy)
            begin
               // R14: identity after dummies
               // R16: nothing while busy
               if (op_ff == `SFE_OP_WAKE_ID && state_ff != ST_WAKE)
               begin
                  tx_on_ff   <= 1'b1;
                  tx_mode_ff <= TX_DEV;
                  tx_byte_ff <= DEV_ID;
                  tx_idx_ff  <= 3'h0;
               end
               // R17: manufacturer then device
               else if (op_ff == `SFE_OP_MANU_DEV_ID && !asleep)
               begin
                  tx_on_ff   <= 1'b1;
                  tx_mode_ff <= TX_PAIR;
                  tx_idx_ff  <= 3'h0;
                  // R18: address one swaps order
                  if (shift_in[23:0] == `SFE_ID_ADDR_DEV_1ST)
                  begin
                     tx_byte_ff <= DEV_ID;
                     tx_alt_ff  <= 1'b0;
                  end
                  else
                  begin
                     tx_byte_ff <= MANU_ID;
                     tx_alt_ff  <= 1'b1;
                  end
               end
            end
         end
         // R14: falling edge output, MSB first
         else if (sclk_fall && tx_on_ff)
         begin
            o_serial_output    <= tx_byte_ff[7];
            o_serial_output_oe <= 1'b1;
            tx_idx_ff          <= tx_idx_ff + 3'h1;
            if (tx_idx_ff == 3'h7)
            begin
               // R18: alternate identity bytes
               tx_byte_ff <= nxt_byte;
               tx_alt_ff  <= ~tx_alt_ff;
            end
            else
               tx_byte_ff <= {tx_byte_ff[6:0], 1'b0};
         end
      end
   end

   // --------------------
   // Protection decode
   // --------------------
   reg  [8:0] prot_cnt;
   reg        blk_prot;
   wire [8:0] req_blk = {1'b0, shift_ff[16 +: 8]} & (NUM_BLK - 9'h001);

   always @*
   begin
      if (bp == 3'h0)
         prot_cnt = 9'h000;
      else if ({6'h00, bp} > BLOCK_BITS)
         prot_cnt = NUM_BLK;
      else
         prot_cnt = 9'h001 << (bp - 3'h1);
      // R6: top or bottom protected range
      if (tb)
         blk_prot = (req_blk < prot_cnt);
      else
         blk_prot = (req_blk >= (NUM_BLK - prot_cnt));
   end

   // --------------------
   // Self-timed operation sequencer
   // --------------------
   reg         tmr_load;
   reg  [31:0] tmr_count;
   wire        tmr_done;

   sfe_timer u_timer
   (
      .i_clk     (i_clk),
      .i_rst_n   (i_rst_n),
      .i_load    (tmr_load),
      .i_count   (tmr_count),
      .o_done    (tmr_done),
      .o_running ()
   );

   wire cmd_blk   = frame_end && bit_cnt_ff == 6'h20 && op_ff == `SFE_OP_BLOCK_ERASE;
   wire cmd_chip  = frame_end && bit_cnt_ff == 6'h08 &&
                    (op_ff == `SFE_OP_CHIP_ERASE_A || op_ff == `SFE_OP_CHIP_ERASE_B);
   wire cmd_sleep = frame_end && bit_cnt_ff == 6'h08 && op_ff == `SFE_OP_SLEEP;
   wire cmd_wake  = frame_end && bit_cnt_ff >= 6'h08 && op_ff == `SFE_OP_WAKE_ID;

   always @*
   begin
      nxt_state = state_ff;
      tmr_load  = 1'b0;
      tmr_count = 32'h0;
      case (state_ff)
         ST_IDLE:
         begin
            // R2: latch gates erase
            // R3: exact length for block erase
            // R6: protected block skipped
            if (cmd_blk && wel_ff && !blk_prot)
            begin
               nxt_state = ST_ERASE;
               tmr_load  = 1'b1;
               // R21: parameterised duration
               tmr_count = BLOCK_ERASE_CYC;
            end
            // R8: exact length for chip erase
            // R9: any protection refuses
            else if (cmd_chip && wel_ff && bp == 3'h0)
            begin
               nxt_state = ST_ERASE;
               tmr_load  = 1'b1;
               tmr_count = CHIP_ERASE_CYC;
            end
            // R10: sleep entry
            else if (cmd_sleep)
            begin
               nxt_state = ST_ENTER;
               tmr_load  = 1'b1;
               tmr_count = SLEEP_CYC;
            end
         end
         ST_ERASE:
         begin
            // R4: busy until timer ends
            if (tmr_done)
               nxt_state = ST_IDLE;
         end
         ST_ENTER:
         begin
            if (tmr_done)
               nxt_state = ST_SLEEP;
         end
         ST_SLEEP:
         begin
            // R11: only wake opcode
            if (cmd_wake)
            begin
               nxt_state = ST_WAKE;
               tmr_load  = 1'b1;
               // R13: bare wake delay
               // R15: identity wake delay
               tmr_count = (bit_cnt_ff == 6'h08) ? WAKE_CYC : WAKE_ID_CYC;
            end
         end
         ST_WAKE:
         begin
            if (tmr_done)
               nxt_state = ST_IDLE;
         end
         default:
            nxt_state = ST_IDLE;
      endcase
   end

   wire erase_go = state_ff[0] && nxt_state == ST_ERASE;

   // --------------------
   // State, latch and erase outputs
   // --------------------
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         // R12: start awake
         state_ff      <= ST_IDLE;
         wel_ff        <= 1'b0;
         prot_ff       <= `SFE_RST_PROTECT;
         last_ff       <= 32'h0;
         count_ff      <= 32'h0;
         o_erase_start <= 1'b0;
         o_erase_all   <= 1'b0;
         o_erase_block <= 8'h00;
         o_asleep      <= 1'b0;
      end
      else
      begin
         state_ff      <= nxt_state;
         o_erase_start <= erase_go;
         o_asleep      <= nxt_state[3] | nxt_state[4];
         if (erase_go)
         begin
            // R20: upper address bits select block
            // R1: block erase to FFh
            // R7: whole array erase
            o_erase_block <= req_blk[7:0];
            o_erase_all   <= cmd_chip;
         end
         if (busy && tmr_done)
         begin
            last_ff  <= {o_erase_all, 23'h0, o_erase_block};
            count_ff <= count_ff + 32'h1;
            // R5: clear latch when erase ends
            wel_ff   <= 1'b0;
         end
         if (i_wr && i_addr == `SFE_ADDR_CTRL)
            wel_ff <= i_wdata[`SFE_CTRL_WEL_BIT];
         if (i_wr && i_addr == `SFE_ADDR_PROTECT)
            prot_ff <= i_wdata[3:0];
      end
   end

   // --------------------
   // Register read port
   // --------------------
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_rdata <= 32'h0;
      else if (i_rd)
      begin
         case (i_addr)
            `SFE_ADDR_CTRL:        o_rdata <= {31'h0, wel_ff};
            `SFE_ADDR_PROTECT:     o_rdata <= {28'h0, prot_ff};
            `SFE_ADDR_STATUS:      o_rdata <= {28'h0, state_ff[4], asleep, wel_ff, busy};
            `SFE_ADDR_LAST_ERASE:  o_rdata <= last_ff;
            `SFE_ADDR_ERASE_COUNT: o_rdata <= count_ff;
            default:               o_rdata <= 32'h0;
         endcase
      end
      else
         o_rdata <= 32'h0;
   end

endmodule

/* File: verification/sfe_host.sv */
// SPI host model framing commands for the sequencer
`timescale 1ns/10ps
module sfe_host
(
   // Link pins
   output reg  o_select_n = 1'b1,
   output reg  o_sclk     = 1'b0,
   output reg  o_mosi     = 1'b0,
   input  wire i_miso,
   input  wire i_miso_oe
);
   // --------------------
   // One frame, bits taken from the top of v
   // --------------------
   task frame(input int n, input logic [63:0] v, input int gap,
              output logic [63:0] rx, output logic saw_oe);
      int i;
      begin
         rx = 64'h0;
         saw_oe = 1'b0;
         o_select_n = 1'b0;
         for (i = 0; i < n; i++)
         begin
            o_mosi = v[63-i];
            #62.5;
            rx = {rx[62:0], i_miso};
            saw_oe = saw_oe | i_miso_oe;
            o_sclk = 1'b1;
            #62.5;
            o_sclk = 1'b0;
         end
         #31;
         o_select_n = 1'b1;
         o_mosi = ~o_mosi;
         #(gap);
      end
   endtask
endmodule

/* File: verification/sfe_sva.sv */
// Port assertions for the erase sequencer
`timescale 1ns/10ps
module sfe_sva
#(
   parameter BLOCK_ERASE_CYC = 100000,
   parameter WAKE_ID_CYC     = 200
)
(
   input wire        i_clk,
   input wire        i_rst_n,
   input wire        i_select_n,
   input wire        i_rd,
   input wire [7:0]  i_addr,
   input wire [31:0] o_rdata,
   input wire        o_serial_output_oe,
   input wire        o_erase_start,
   input wire        o_asleep
);
   reg [31:0] gap_ff;
   reg [31:0] hi_ff;
   // --------------------
   // Cycle counters
   // --------------------
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         gap_ff <= 32'hFFFFFFFF;
      else if (o_erase_start)
         gap_ff <= 32'h0;
      else if (gap_ff != 32'hFFFFFFFF)
         gap_ff <= gap_ff + 32'h1;
   end
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         hi_ff <= 32'h0;
      else if (!i_select_n)
         hi_ff <= 32'h0;
      else if (hi_ff != 32'hFFFFFFFF)
         hi_ff <= hi_ff + 32'h1;
   end
   // --------------------
   // Properties
   // --------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   property p_start_pulse; o_erase_start |=> !o_erase_start; endproperty
   a_start_pulse: assert property (p_start_pulse)
      else $error("erase start longer than one cycle");
   property p_start_idle; o_erase_start |-> $past(i_select_n, 1) && $past(i_select_n, 2); endproperty
   a_start_idle: assert property (p_start_idle)
      else $error("erase started inside a frame");
   property p_spacing; o_erase_start |-> gap_ff >= BLOCK_ERASE_CYC; endproperty
   a_spacing: assert property (p_spacing)
      else $error("erase started while busy");
   property p_rdata_idle; !$past(i_rd) |-> o_rdata == 32'h0; endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data outside read cycle");
   property p_unmapped; $past(i_rd) && $past(i_addr) == 8'h20 |-> o_rdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_oe_off; i_select_n [*5] |-> !o_serial_output_oe; endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("output driven while deselected");
   property p_sleep_quiet; o_asleep |-> !o_erase_start; endproperty
   a_sleep_quiet: assert property (p_sleep_quiet)
      else $error("erase started while asleep");
   property p_asleep_rise; $rose(o_asleep) |-> i_select_n; endproperty
   a_asleep_rise: assert property (p_asleep_rise)
      else $error("sleep entered inside a frame");
   property p_asleep_fall; $fell(o_asleep) |-> hi_ff >= WAKE_ID_CYC; endproperty
   a_asleep_fall: assert property (p_asleep_fall)
      else $error("woke before wake delay");
endmodule

/* File: verification/tb.sv */
// Self-checking testbench of the erase sequencer
`timescale 1ns/10ps
`include "sfe_regs.vh"
module tb;
   typedef struct {
      logic [7:0]  op;
      int          n;
      logic [23:0] addr;
      logic        write_enable_latch;
      logic [3:0]  prot;
      logic        go;
      logic [7:0]  blk;
   } sfe_row_t;
   localparam [7:0] MANU = 8'hC3;   // arbitrary identity value
   localparam [7:0] DEV  = 8'h2D;   // arbitrary identity value
   logic        i_clk = 1'b0;
   logic        i_rst_n = 1'b0;
   logic [7:0]  i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   wire         select_n, sclk, mosi, miso, miso_oe, erase_start, erase_all, asleep;
   wire  [7:0]  erase_block;
   wire  [31:0] rdata;
   logic [31:0] n_start = 32'h0;
   logic [31:0] d, n0, cnt;
   logic [63:0] rx;
   logic        oe, all;
   int          checks = 0;
   int          n_fail = 0;
   int          r;
   sfe_row_t    rows [13];
   always #5 i_clk = ~i_clk;
   always @(posedge i_clk) if (erase_start === 1'b1) n_start <= n_start + 32'h1;
   sfe_top #(.MANU_ID(MANU), .DEV_ID(DEV), .BLOCK_ERASE_CYC(700), .CHIP_ERASE_CYC(800),
             .SLEEP_CYC(40), .WAKE_CYC(40), .WAKE_ID_CYC(30)) dut
      (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_select_n(select_n), .i_sclk(sclk),
       .i_serial_input_line(mosi), .o_serial_output(miso), .o_serial_output_oe(miso_oe),
       .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
       .o_erase_start(erase_start), .o_erase_all(erase_all), .o_erase_block(erase_block),
       .o_asleep(asleep));
   sfe_host host (.o_select_n(select_n), .o_sclk(sclk), .o_mosi(mosi), .i_miso(miso),
                  .i_miso_oe(miso_oe));
   // --------------------
   // Bus and checking tasks
   // --------------------
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task print_verdict;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 v = rdata;
   endtask
   task wait_idle;
      int k;
      begin
         d = 32'h1;
         for (k = 0; k < 1000 && d[0] !== 1'b0; k++)
            rd(`SFE_ADDR_STATUS, d);
         if (d[0] !== 1'b0)
         begin
            check("idle timeout", d, 32'h0);
            print_verdict;
         end
      end
   endtask
   // --------------------
   // Main sequence
   // --------------------
   initial
   begin
      rows = '{'{8'hD8, 32, 24'h051234, 1'h1, 4'h0, 1'h1, 8'h05},
               '{8'hD8, 32, 24'h070000, 1'h1, 4'h1, 1'h0, 8'h00},
               '{8'hD8, 32, 24'h07FFFF, 1'h1, 4'h9, 1'h1, 8'h07},
               '{8'hD8, 32, 24'h000000, 1'h1, 4'h9, 1'h0, 8'h00},
               '{8'hD8, 32, 24'h060000, 1'h1, 4'h2, 1'h0, 8'h00},
               '{8'hD8, 32, 24'h030000, 1'h0, 4'h0, 1'h0, 8'h00},
               '{8'hD8, 31, 24'h030000, 1'h1, 4'h0, 1'h0, 8'h00},
               '{8'hD8, 33, 24'h030000, 1'h1, 4'h0, 1'h0, 8'h00},
               '{8'hC7, 8, 24'h000000, 1'h1, 4'h0, 1'h1, 8'h00},
               '{8'h60, 8, 24'h000000, 1'h1, 4'h0, 1'h1, 8'h00},
               '{8'hC7, 9, 24'h000000, 1'h1, 4'h0, 1'h0, 8'h00},
               '{8'h60, 8, 24'h000000, 1'h1, 4'h9, 1'h0, 8'h00},
               '{8'hC7, 8, 24'h000000, 1'h1, 4'h8, 1'h1, 8'h00}};
      repeat (10) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_clk);
      check("asleep after reset", {31'h0, asleep}, 32'h0);
      wr(8'h20, 32'hFFFF_FFFF);
      foreach (rows[i])
      begin
         rd(8'h00 + 8'(i * 4), d);
         if (i < 6)
            check("reset or unmapped", d, 32'h0);
      end
      cnt = 32'h0;
      for (r = 0; r < 13; r++)
      begin
         wr(`SFE_ADDR_PROTECT, {28'h0, rows[r].prot});
         wr(`SFE_ADDR_CTRL, {31'h0, rows[r].write_enable_latch});
         n0 = n_start;
         host.frame(rows[r].n, {rows[r].op, rows[r].addr, 32'h0}, 1000, rx, oe);
         check("erase start", n_start - n0, {31'h0, rows[r].go});
         all = (rows[r].op != 8'hD8);
         if (rows[r].go)
         begin
            check("erase all", {31'h0, erase_all}, {31'h0, all});
            if (!all)
               check("erase block", {24'h0, erase_block}, {24'h0, rows[r].blk});
            rd(`SFE_ADDR_STATUS, d);
            check("busy", d, 32'h3);
            wait_idle;
            check("status done", d, 32'h0);
            rd(`SFE_ADDR_LAST_ERASE, d);
            if (all)
               check("last chip", {31'h0, d[31]}, 32'h1);
            else
               check("last block", d, {24'h0, rows[r].blk});
            cnt = cnt + 32'h1;
            rd(`SFE_ADDR_ERASE_COUNT, d);
            check("erase count", d, cnt);
         end
         else
         begin
            rd(`SFE_ADDR_STATUS, d);
            check("latch kept", d, {30'h0, rows[r].write_enable_latch, 1'h0});
         end
      end
      wr(`SFE_ADDR_PROTECT, 32'h0);
      wr(`SFE_ADDR_CTRL, 32'h1);
      host.frame(32, {8'hD8, 24'h020000, 32'h0}, 200, rx, oe);
      host.frame(16, {8'h05, 56'h0}, 200, rx, oe);
      check("spi status busy", {24'h0, rx[7:0]}, 32'h3);
      host.frame(48, {8'hAB, 56'h0}, 200, rx, oe);
      check("id ignored busy", {31'h0, oe}, 32'h0);
      wait_idle;
      rd(`SFE_ADDR_ERASE_COUNT, d);
      check("erase survives", d, cnt + 32'h1);
      host.frame(48, {8'hAB, 56'h0}, 1000, rx, oe);
      check("device id", {16'h0, rx[15:0]}, {16'h0, DEV, DEV});
      host.frame(64, {8'h90, 24'h000000, 32'h0}, 1000, rx, oe);
      check("manu dev", rx[31:0], {MANU, DEV, MANU, DEV});
      host.frame(64, {8'h90, 24'h000001, 32'h0}, 1000, rx, oe);
      check("dev manu", rx[31:0], {DEV, MANU, DEV, MANU});
      host.frame(9, {8'hB9, 56'h0}, 1000, rx, oe);
      check("sleep bad count", {31'h0, asleep}, 32'h0);
      host.frame(8, {8'hB9, 56'h0}, 1000, rx, oe);
      check("sleep entered", {31'h0, asleep}, 32'h1);
      wr(`SFE_ADDR_CTRL, 32'h1);
      n0 = n_start;
      host.frame(8, {8'hC7, 56'h0}, 1000, rx, oe);
      check("erase while asleep", n_start - n0, 32'h0);
      host.frame(16, {8'h05, 56'h0}, 1000, rx, oe);
      check("status while asleep", {31'h0, oe}, 32'h0);
      host.frame(64, {8'h90, 56'h0}, 1000, rx, oe);
      check("id while asleep", {31'h0, oe}, 32'h0);
      host.frame(8, {8'hAB, 56'h0}, 100, rx, oe);
      check("still waking", {31'h0, asleep}, 32'h1);
      repeat (60) @(posedge i_clk);
      check("woken", {31'h0, asleep}, 32'h0);
      host.frame(8, {8'hB9, 56'h0}, 1000, rx, oe);
      host.frame(48, {8'hAB, 56'h0}, 100, rx, oe);
      check("wake id", {16'h0, rx[15:0]}, {16'h0, DEV, DEV});
      check("id waking", {31'h0, asleep}, 32'h1);
      repeat (60) @(posedge i_clk);
      check("id woken", {31'h0, asleep}, 32'h0);
      host.frame(16, {8'h05, 56'h0}, 1000, rx, oe);
      check("status after wake", {24'h0, rx[7:0]}, 32'h2);
      print_verdict;
   end
endmodule
bind sfe_top sfe_sva #(.BLOCK_ERASE_CYC(BLOCK_ERASE_CYC), .WAKE_ID_CYC(WAKE_ID_CYC)) u_sva
   (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_select_n(i_select_n), .i_rd(i_rd),
    .i_addr(i_addr), .o_rdata(o_rdata), .o_serial_output_oe(o_serial_output_oe),
    .o_erase_start(o_erase_start), .o_asleep(o_asleep));
